// *** fsc_pkg.sv ***
// constants and types for the filter serial control block
package fsc_pkg;
  // ==========================================================
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam logic [4:0] CNT_HDR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_LAST = 5'h0F;
  localparam logic [4:0] CNT_FRAME = 5'h10;
  localparam int HDR_START_BIT = 7;
  localparam int HDR_RSV_HI = 6;
  localparam int HDR_RSV_LO = 5;
  localparam int HDR_RW_BIT = 4;
  localparam logic [3:0] ADDR_CORNER = 4'h0;
  localparam logic [3:0] ADDR_BAND = 4'h1;
  localparam logic [3:0] ADDR_GAIN = 4'h2;
  // ==========================================================
  // register fields and masks
  localparam logic [7:0] MASK_CORNER = 8'hFF;
  localparam logic [7:0] MASK_BAND = 8'h7F;
  localparam logic [7:0] MASK_GAIN = 8'h1F;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CAL_LOW_HI = 4;
  localparam int CAL_LOW_LO = 0;
  localparam int FINE_HI = 2;
  localparam int FINE_LO = 0;
  // ==========================================================
  // timing
  localparam int MCLK_MHZ = 100;
  localparam logic [5:0] CAL_REF_CYCLES = 6'd50;
  localparam int STALL_NS = 1000;
  localparam int STALL_CYC_INT = (STALL_NS * MCLK_MHZ + 999) / 1000;
  localparam logic [7:0] STALL_CYCLES = 8'(STALL_CYC_INT);
  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] gain_setting;
    logic [7:0] band_and_cal_constant;
    logic [7:0] corner_tune_and_cal_constant;
  } fsc_cfg_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MANUAL,
    ST_CAL,
    ST_DONE
  } fsc_cal_state_type;
endpackage

// *** fsc_top.sv ***
// serial register port and calibration sequencer of the filter control
`timescale 1ns/100ps
module fsc_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // serial link pins
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_latch_strobe,
  output logic o_sdata,
  output logic o_sdata_oe,
  // control pins
  input wire logic i_register_clear,
  input wire logic i_chip_enable,
  input wire logic i_calibration_enable,
  input wire logic [5:0] i_manual_tune,
  input wire logic i_ref_clk,
  input wire logic i_ref_clk_select,
  // filter control outputs
  output fsc_pkg::fsc_cfg_type o_cfg,
  output logic o_isolate,
  output logic o_tuned,
  output logic o_manual_mode,
  output logic [5:0] o_tune_code,
  output logic o_ref_fast,
  output logic o_settle_error_low,
  output logic o_settle_error_high
);
  // ==========================================================
  // helpers
  // header and address check
  function automatic logic hdr_ok(input logic [7:0] hdr);
    hdr_ok = hdr[fsc_pkg::HDR_START_BIT] && !hdr[fsc_pkg::HDR_RSV_HI] &&
             !hdr[fsc_pkg::HDR_RSV_LO] &&
             (hdr[3:0] == fsc_pkg::ADDR_CORNER ||
              hdr[3:0] == fsc_pkg::ADDR_BAND ||
              hdr[3:0] == fsc_pkg::ADDR_GAIN);
  endfunction

  function automatic logic [7:0] reg_read(input fsc_pkg::fsc_cfg_type c,
                                          input logic [3:0] a);
    case (a)
      fsc_pkg::ADDR_CORNER: reg_read = c.corner_tune_and_cal_constant;
      fsc_pkg::ADDR_BAND: reg_read = c.band_and_cal_constant;
      fsc_pkg::ADDR_GAIN: reg_read = c.gain_setting;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [2:0] sclk_q, le_q, cal_q, ref_q;
  logic [1:0] sd_q, clr_q, ce_q, sel_q;
  logic [5:0] man1_q, man2_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sclk_q <= 3'h0;
      le_q <= 3'h7;
      cal_q <= 3'h0;
      ref_q <= 3'h0;
      sd_q <= 2'h0;
      clr_q <= 2'h0;
      ce_q <= 2'h0;
      sel_q <= 2'h0;
      man1_q <= 6'h00;
      man2_q <= 6'h00;
    end else begin
      sclk_q <= {sclk_q[1:0], i_sclk};
      le_q <= {le_q[1:0], i_latch_strobe};
      cal_q <= {cal_q[1:0], i_calibration_enable};
      ref_q <= {ref_q[1:0], i_ref_clk};
      sd_q <= {sd_q[0], i_sdata};
      clr_q <= {clr_q[0], i_register_clear};
      ce_q <= {ce_q[0], i_chip_enable};
      sel_q <= {sel_q[0], i_ref_clk_select};
      man1_q <= i_manual_tune;
      man2_q <= man1_q;
    end
  end

  logic sclk_rise, le_fall, le_rise, cal_fall, ref_rise, le_low;
  assign sclk_rise = sclk_q[1] && !sclk_q[2];
  assign le_fall = !le_q[1] && le_q[2];
  assign le_rise = le_q[1] && !le_q[2];
  assign le_low = !le_q[1];
  assign cal_fall = !cal_q[1] && cal_q[2];
  assign ref_rise = ref_q[1] && !ref_q[2];

  // ==========================================================
  // serial shifter
  logic [15:0] shift_q, shift_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] tx_q, tx_d;
  logic sdo_q, sdo_d, oe_q, oe_d;
  logic [7:0] hdr_now, rd_byte;
  fsc_pkg::fsc_cfg_type cfg_q, cfg_d;

  assign hdr_now = {shift_q[6:0], sd_q[1]};
  assign rd_byte = reg_read(cfg_q, hdr_now[3:0]);

  always_comb begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    if (le_fall) begin
      shift_d = 16'h0000;
      cnt_d = 5'h00;
      oe_d = 1'b0;
      sdo_d = 1'b0;
    end else if (le_low && sclk_rise && cnt_q < fsc_pkg::CNT_FRAME) begin
      shift_d = {shift_q[14:0], sd_q[1]};
      cnt_d = cnt_q + 5'h01;
      if (cnt_q == fsc_pkg::CNT_HDR_LAST) begin
        if (hdr_now[fsc_pkg::HDR_RW_BIT] && hdr_ok(hdr_now)) begin
          oe_d = 1'b1;
          sdo_d = rd_byte[7];
          tx_d = {rd_byte[6:0], 1'b0};
        end
      end else if (oe_q) begin
        sdo_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
        if (cnt_q == fsc_pkg::CNT_DATA_LAST) begin
          oe_d = 1'b0;
        end
      end
    end
    if (!le_low) begin
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      shift_q <= 16'h0000;
      cnt_q <= 5'h00;
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
    end
  end

  // ==========================================================
  // configuration registers
  localparam int HDR_BITS_POS = fsc_pkg::HDR_BITS + fsc_pkg::HDR_RW_BIT;
  logic wr_go;
  assign wr_go = le_rise && cnt_q == fsc_pkg::CNT_FRAME &&
                 !shift_q[HDR_BITS_POS] && hdr_ok(shift_q[15:8]);

  always_comb begin
    cfg_d = cfg_q;
    if (clr_q[1]) begin
      cfg_d = '0;
    end else if (wr_go) begin
      case (shift_q[11:8])
        fsc_pkg::ADDR_CORNER: cfg_d.corner_tune_and_cal_constant =
          shift_q[7:0] & fsc_pkg::MASK_CORNER;
        fsc_pkg::ADDR_BAND: cfg_d.band_and_cal_constant =
          shift_q[7:0] & fsc_pkg::MASK_BAND;
        fsc_pkg::ADDR_GAIN: cfg_d.gain_setting =
          shift_q[7:0] & fsc_pkg::MASK_GAIN;
        default: cfg_d = cfg_q;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cfg_q <= {fsc_pkg::CFG_RESET, fsc_pkg::CFG_RESET, fsc_pkg::CFG_RESET};
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ==========================================================
  // calibration sequencer
  fsc_pkg::fsc_cal_state_type st_q, st_d;
  logic [5:0] ref_cnt_q, ref_cnt_d;
  logic [7:0] stall_q, stall_d;
  logic err_lo_q, err_lo_d, err_hi_q, err_hi_d;
  logic iso_q, iso_d;
  logic [5:0] code_q, code_d;
  logic tuned_q, tuned_d, manual_q, manual_d;
  logic [4:0] cal_low;
  assign cal_low = cfg_q.band_and_cal_constant[fsc_pkg::CAL_LOW_HI:
                                               fsc_pkg::CAL_LOW_LO];

  always_comb begin
    st_d = st_q;
    ref_cnt_d = ref_cnt_q;
    stall_d = stall_q;
    err_lo_d = err_lo_q;
    err_hi_d = err_hi_q;
    if (!ce_q[1]) begin
      st_d = fsc_pkg::ST_IDLE;
    end else if (cal_q[1]) begin
      st_d = fsc_pkg::ST_MANUAL;
    end else begin
      case (st_q)
        fsc_pkg::ST_MANUAL: begin
          if (cal_fall) begin
            ref_cnt_d = 6'h00;
            stall_d = 8'h00;
            err_lo_d = 1'b0;
            err_hi_d = (cal_low == 5'h00);
            st_d = (cal_low == 5'h00) ? fsc_pkg::ST_IDLE : fsc_pkg::ST_CAL;
          end else begin
            st_d = fsc_pkg::ST_IDLE;
          end
        end
        fsc_pkg::ST_CAL: begin
          if (ref_rise) begin
            stall_d = 8'h00;
            ref_cnt_d = ref_cnt_q + 6'h01;
            if (ref_cnt_q == fsc_pkg::CAL_REF_CYCLES - 6'h01) begin
              st_d = fsc_pkg::ST_DONE;
            end
          end else if (stall_q == fsc_pkg::STALL_CYCLES - 8'h01) begin
            err_lo_d = 1'b1;
            st_d = fsc_pkg::ST_IDLE;
          end else begin
            stall_d = stall_q + 8'h01;
          end
        end
        fsc_pkg::ST_DONE: st_d = fsc_pkg::ST_DONE;
        fsc_pkg::ST_IDLE: st_d = fsc_pkg::ST_IDLE;
        default: st_d = fsc_pkg::ST_IDLE;
      endcase
    end
    iso_d = !(ce_q[1] && (st_d == fsc_pkg::ST_DONE ||
                          st_d == fsc_pkg::ST_MANUAL));
    code_d = (st_d == fsc_pkg::ST_MANUAL) ? man2_q :
      {3'h0, cfg_q.corner_tune_and_cal_constant[fsc_pkg::FINE_HI:
                                                fsc_pkg::FINE_LO]};
    tuned_d = (st_d == fsc_pkg::ST_DONE);
    manual_d = (st_d == fsc_pkg::ST_MANUAL);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q <= fsc_pkg::ST_IDLE;
      ref_cnt_q <= 6'h00;
      stall_q <= 8'h00;
      err_lo_q <= 1'b0;
      err_hi_q <= 1'b0;
      iso_q <= 1'b1;
      code_q <= 6'h00;
      tuned_q <= 1'b0;
      manual_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ref_cnt_q <= ref_cnt_d;
      stall_q <= stall_d;
      err_lo_q <= err_lo_d;
      err_hi_q <= err_hi_d;
      iso_q <= iso_d;
      code_q <= code_d;
      tuned_q <= tuned_d;
      manual_q <= manual_d;
    end
  end

  // ==========================================================
  // outputs
  logic sel_fast_q;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sel_fast_q <= 1'b0;
    end else begin
      sel_fast_q <= sel_q[1];
    end
  end

  assign o_sdata = sdo_q;
  assign o_sdata_oe = oe_q;
  assign o_cfg = cfg_q;
  assign o_isolate = iso_q;
  assign o_tuned = tuned_q;
  assign o_manual_mode = manual_q;
  assign o_tune_code = code_q;
  assign o_ref_fast = sel_fast_q;
  assign o_settle_error_low = err_lo_q;
  assign o_settle_error_high = err_hi_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_hdr_read_ok;
    le_low && sclk_rise && cnt_q == fsc_pkg::CNT_HDR_LAST &&
    hdr_now[fsc_pkg::HDR_RW_BIT] && hdr_ok(hdr_now) && !le_fall;
  endsequence
  sequence s_cal_start;
    ce_q[1] && !cal_q[1] && st_q == fsc_pkg::ST_MANUAL && cal_fall &&
    cal_low != 5'h00;
  endsequence

  property p_bit_count;
    le_low && !le_fall && sclk_rise && cnt_q < fsc_pkg::CNT_FRAME |=>
      cnt_q == $past(cnt_q) + 5'h01;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("serial bit not counted");

  property p_write_load;
    wr_go && !clr_q[1] && shift_q[11:8] == fsc_pkg::ADDR_GAIN |=>
      o_cfg.gain_setting == ($past(shift_q[7:0]) & fsc_pkg::MASK_GAIN);
  endproperty
  a_write_load: assert property (p_write_load)
    else $error("gain register not loaded");

  property p_short_frame;
    le_rise && cnt_q != fsc_pkg::CNT_FRAME && !clr_q[1] |=> $stable(cfg_q);
  endproperty
  a_short_frame: assert property (p_short_frame)
    else $error("short frame changed registers");

  property p_read_drive;
    s_hdr_read_ok |=> o_sdata_oe &&
      o_sdata == $past(rd_byte[7]);
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data not driven");

  property p_bad_hdr;
    le_low && sclk_rise && cnt_q == fsc_pkg::CNT_HDR_LAST &&
      !hdr_ok(hdr_now) && !oe_q |=> !o_sdata_oe;
  endproperty
  a_bad_hdr: assert property (p_bad_hdr)
    else $error("bad header drove the line");

  property p_clear;
    clr_q[1] |=> o_cfg == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("registers not cleared");

  property p_standby;
    !ce_q[1] |=> o_isolate && !o_tuned ##1 o_isolate;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not isolated");

  property p_cal_start;
    s_cal_start |=> st_q == fsc_pkg::ST_CAL && ref_cnt_q == 6'h00;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration did not start");

  property p_cal_done;
    st_q == fsc_pkg::ST_CAL && ref_rise && ce_q[1] && !cal_q[1] &&
      ref_cnt_q == fsc_pkg::CAL_REF_CYCLES - 6'h01 |=> o_tuned && !o_isolate;
  endproperty
  a_cal_done: assert property (p_cal_done)
    else $error("tuned flag missing after calibration");

  property p_manual;
    ce_q[1] && cal_q[1] |=> o_manual_mode && o_tune_code == $past(man2_q);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual mode not entered");
endmodule

// *** fsc_host_model.sv ***
// host controller model driving the three-wire serial link
`timescale 1ns/100ps
module fsc_host_model (
  // link pins
  input wire logic i_line,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_drive,
  output logic o_latch_strobe
);
  // ==========================================================
  // link timing
  // 125 ns link period
  localparam real HALF_NS = 62.5;
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_drive = 1'b0;
    o_latch_strobe = 1'b1;
  end
  // ==========================================================
  // one frame; read data returned in rd
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] dat,
                      output logic [7:0] rd);
    logic [15:0] word;
    word = {hdr, dat};
    rd = 8'h00;
    // keep link edges clear of system clock edges
    #2;
    // strobe low only for own frame
    o_latch_strobe = 1'b0;
    #(HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b0;
      if (i >= 8 || !hdr[4]) begin
        o_drive = 1'b1;
        o_sdata = word[i];
      end
      #(HALF_NS);
      o_sclk = 1'b1;
      if (i < 8) rd[i] = i_line;
      #15;
      // hold past the sampling edge, release before the answer
      if (hdr[4] && i == 8) o_drive = 1'b0;
      #(HALF_NS - 15);
    end
    // clock stands low between frames
    o_sclk = 1'b0;
    #(HALF_NS);
    o_latch_strobe = 1'b1;
    o_drive = 1'b0;
    #500;
  endtask
endmodule

// *** test_filter_serial_control_calibration.sv ***
// self-checking bench of the filter serial control block
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  bad_count++; $display("BAD %0t value %h expected %h", $time, got, exp); \
  end end
module test_filter_serial_control_calibration;
  // ==========================================================
  // signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  logic ce = 1'b0;
  logic cal = 1'b0;
  logic [5:0] man = 6'h00;
  logic ref_clk = 1'b0;
  logic ref_on = 1'b0;
  logic ref_sel = 1'b0;
  logic h_sclk, h_sdata, h_drive, h_le, d_sdata, d_oe, line, line_last;
  logic tuned, isolate, manual, fast, err_lo, err_hi, oe_seen;
  logic [5:0] tune_code;
  logic [7:0] rd;
  fsc_pkg::fsc_cfg_type cfg;
  int bad_count = 0;
  int compares = 0;
  int ref_rises = 0;
  always #5 mclk = ~mclk;
  always begin
    #25;
    ref_clk = ref_on ? ~ref_clk : 1'b0;
  end
  always @(posedge ref_clk) ref_rises++;
  always @(posedge mclk) if (d_oe === 1'b1) oe_seen <= 1'b1;
  // released line shows the inverse of its last driven level
  always @* begin
    if (d_oe) line_last = d_sdata;
    else if (h_drive) line_last = h_sdata;
  end
  assign line = d_oe ? d_sdata : (h_drive ? h_sdata : ~line_last);
  // ==========================================================
  // instances
  fsc_host_model host_u (.i_line(line), .o_sclk(h_sclk), .o_sdata(h_sdata),
    .o_drive(h_drive), .o_latch_strobe(h_le));
  fsc_top dut_u (.i_mclk(mclk), .i_rst(rst), .i_sclk(h_sclk),
    .i_sdata(line), .i_latch_strobe(h_le), .o_sdata(d_sdata),
    .o_sdata_oe(d_oe), .i_register_clear(clr), .i_chip_enable(ce),
    .i_calibration_enable(cal), .i_manual_tune(man), .i_ref_clk(ref_clk),
    .i_ref_clk_select(ref_sel), .o_cfg(cfg), .o_isolate(isolate),
    .o_tuned(tuned), .o_manual_mode(manual), .o_tune_code(tune_code),
    .o_ref_fast(fast), .o_settle_error_low(err_lo),
    .o_settle_error_high(err_hi));
  // ==========================================================
  // helpers
  function automatic logic [7:0] hdr(input logic rw, input logic [3:0] a);
    return {1'b1, 2'b00, rw, a};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_u.xfer(hdr(1'b0, a), d, rd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic test_done();
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cal_pulse();
    cyc(1);
    cal = 1'b1;
    cyc(6);
    cal = 1'b0;
    cyc(6);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_write_read();
    wr(4'h0, 8'h7D);
    wr(4'h1, 8'hCF);
    wr(4'h2, 8'hEE);
    `CHK(cfg, 24'h0E4F7D)
    host_u.xfer(hdr(1'b1, 4'h2), 8'h00, rd);
    `CHK(rd, 8'h0E)
    host_u.xfer(hdr(1'b1, 4'h0), 8'h00, rd);
    `CHK(rd, 8'h7D)
    host_u.xfer(hdr(1'b1, 4'h1), 8'h00, rd);
    `CHK(rd, 8'h4F)
    `CHK(d_oe, 1'b0)
  endtask
  task automatic t_refuse();
    host_u.xfer(8'h00, 8'h11, rd);
    wr(4'h3, 8'h22);
    wr(4'hF, 8'h33);
    `CHK(cfg, 24'h0E4F7D)
    oe_seen = 1'b0;
    host_u.xfer(hdr(1'b1, 4'h3), 8'h00, rd);
    `CHK(oe_seen, 1'b0)
  endtask
  task automatic t_manual_cal();
    cyc(1);
    ce = 1'b1;
    man = 6'h2A;
    cyc(1);
    cal = 1'b1;
    cyc(6);
    `CHK(manual, 1'b1)
    `CHK(tune_code, 6'h2A)
    cal = 1'b0;
    cyc(6);
    `CHK(isolate, 1'b1)
    `CHK(tuned, 1'b0)
    ref_rises = 0;
    ref_on = 1'b1;
    for (int i = 0; i < 600 && tuned !== 1'b1; i++) cyc(1);
    `CHK(ref_rises, 50)
    `CHK(tuned, 1'b1)
    `CHK(isolate, 1'b0)
    if (tuned !== 1'b1) test_done();
    ref_on = 1'b0;
    cyc(150);
    `CHK(tuned, 1'b1)
    `CHK(tune_code, 6'h05)
  endtask
  task automatic t_standby();
    ce = 1'b0;
    cyc(5);
    `CHK(isolate, 1'b1)
    `CHK(tuned, 1'b0)
    `CHK(cfg, 24'h0E4F7D)
    ce = 1'b1;
    cyc(20);
    `CHK(isolate, 1'b1)
  endtask
  task automatic t_clear_errors();
    clr = 1'b1;
    cyc(3);
    `CHK(cfg, 24'h000000)
    clr = 1'b0;
    cyc(2);
    cal_pulse();
    `CHK(err_hi, 1'b1)
    `CHK(tuned, 1'b0)
    wr(4'h1, 8'h0F);
    cal_pulse();
    cyc(120);
    `CHK(err_lo, 1'b1)
    `CHK(err_hi, 1'b0)
    `CHK(tuned, 1'b0)
    ref_sel = 1'b1;
    cyc(4);
    `CHK(fast, 1'b1)
  endtask
  // ==========================================================
  // main sequence
  initial begin
    cyc(2);
    rst = 1'b0;
    cyc(6);
    `CHK(cfg, 24'h000000)
    `CHK(isolate, 1'b1)
    `CHK(tuned, 1'b0)
    t_write_read();
    t_refuse();
    t_manual_cal();
    t_standby();
    t_clear_errors();
    test_done();
  end
endmodule
